//--- dbr_pkg.sv
// constants shared by the block address and defect remap design
package dbr_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DBR_OFS_CTRL = 8'h00;
  localparam logic [7:0] DBR_OFS_LBN = 8'h04;
  localparam logic [7:0] DBR_OFS_RESULT = 8'h08;
  localparam logic [7:0] DBR_OFS_STATUS = 8'h0c;
  localparam logic [7:0] DBR_OFS_FMT_TRACK = 8'h10;
  localparam logic [7:0] DBR_OFS_DEFECT0 = 8'h14;
  localparam logic [7:0] DBR_OFS_DEFECT1 = 8'h18;
  localparam logic [7:0] DBR_OFS_DEFECT2 = 8'h1c;
  localparam logic [7:0] DBR_OFS_TBL_IDX = 8'h20;
  localparam logic [7:0] DBR_OFS_TBL_DATA = 8'h24;
  localparam logic [7:0] DBR_OFS_ALT = 8'h28;
  localparam logic [7:0] DBR_OFS_SCAN_TGT = 8'h2c;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int DBR_CTRL_FOUR_HEAD = 0;
  localparam int DBR_CTRL_WRITE_OP = 1;
  localparam int DBR_CTRL_ID_RETRY_LO = 2;
  localparam int DBR_CTRL_GO_CONV = 8;
  localparam int DBR_CTRL_GO_FMT = 9;
  localparam int DBR_CTRL_GO_SCAN = 10;
  localparam logic [31:0] DBR_CTRL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // geometry and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] DBR_LBN_MAX_2H = 16'h75ab;
  localparam logic [15:0] DBR_LBN_MAX_4H = 16'heb57;
  localparam logic [15:0] DBR_BLOCKS_PER_TRACK = 16'h0022;
  localparam logic [6:0] DBR_SECTORS = 7'h46;
  localparam logic [6:0] DBR_HALF_SECTORS = 7'h23;
  localparam logic [6:0] DBR_HEAD_SKEW = 7'h0e;
  localparam logic [6:0] DBR_SPARE_A = 7'h44;
  localparam logic [6:0] DBR_SPARE_B = 7'h45;
  localparam logic [9:0] DBR_SPARE_CYL = 10'h1bb;
  localparam logic [7:0] DBR_ID_STEP = 8'h40;

  // ---------------------------------------------------------------
  // sector id flag byte bits
  // ---------------------------------------------------------------
  localparam logic [7:0] DBR_FLAG_ALTERNATE = 8'h80;
  localparam logic [7:0] DBR_FLAG_DEFECTIVE = 8'h40;
  localparam logic [7:0] DBR_FLAG_REASSIGNED = 8'h20;
  localparam logic [7:0] DBR_FLAG_DISP1 = 8'h10;
  localparam logic [7:0] DBR_FLAG_DISP2 = 8'h08;

endpackage

//--- dbr_div.sv
// serial restoring divider for block number to track and offset
`timescale 1ns/1ps
module dbr_div
  import dbr_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [W-1:0] quot,
  output logic [W-1:0] rem
);

  logic [W-1:0] acc_reg;
  logic [W-1:0] q_reg;
  logic [$clog2(W+1)-1:0] cnt_reg;
  logic [W:0] trial;

  assign trial = {acc_reg, q_reg[W-1]} - {1'b0, divisor};
  assign quot = q_reg;
  assign rem = acc_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= '0;
      q_reg <= '0;
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        acc_reg <= '0;
        q_reg <= dividend;
        cnt_reg <= ($clog2(W+1))'(W);
        busy <= 1'b1;
      end else if (busy) begin
        if (!trial[W]) begin
          acc_reg <= trial[W-1:0];
          q_reg <= {q_reg[W-2:0], 1'b1};
        end else begin
          acc_reg <= {acc_reg[W-2:0], q_reg[W-1]};
          q_reg <= {q_reg[W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 1'b1;
        if (cnt_reg == 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

//--- dbr_scan.sv
// searches the track table for the position whose id names a sector
`timescale 1ns/1ps
module dbr_scan
  import dbr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [6:0] target,
  input wire logic [14:0] rd_data,
  output logic [6:0] rd_addr,
  output logic busy,
  output logic found,
  output logic [6:0] phys
);

  logic hit;

  // a live id: logical field matches and the sector is not marked defective
  assign hit = (rd_data[6:0] == target) && ((rd_data[14:7] & DBR_FLAG_DEFECTIVE) == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_addr <= '0;
      busy <= 1'b0;
      found <= 1'b0;
      phys <= '0;
    end else if (start) begin
      rd_addr <= '0;
      busy <= 1'b1;
      found <= 1'b0;
    end else if (busy) begin
      if (hit) begin
        busy <= 1'b0;
        found <= 1'b1;
        phys <= rd_addr;
      end else if (rd_addr == DBR_SECTORS - 7'h01) begin
        busy <= 1'b0;
      end else begin
        rd_addr <= rd_addr + 7'h01;
      end
    end
  end

endmodule

//--- dbr_top.sv
// apb block address converter and track defect remap planner
// Function
// [R1] first defect becomes 68, flags 6 and 4
// [R2] later sectors shift as if defect absent
// [R3] defective 68 and 69 only: no displacement
// [R4] second defect becomes 69, flags 6 and 3
// [R5] bit 3 marks second defect and followers
// [R6] third defect: flags 6,5, cylinder 443
// [R7] third defect in displaced band also displaced
// [R8] alternate carries replaced address, flag 7
// [R9] failed id moves 64, then 128 bytes
// [R10] defect map track never formatted or written
// [R11] block number limit per head count
// [R12] block is track times 34 plus sector/2
// [R13] block spans even then odd sector
// [R14] block number becomes cylinder, head, sector
// [R15] clean track interleaves 0,35,1,36 onward
// [R16] each head rotates numbering 14 positions
// [R17] locate sector by matching id field
`timescale 1ns/1ps
module dbr_top
  import dbr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [9:0] DEFECT_MAP_CYL = 10'h1bd
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef enum logic [0:0] {
    DBR_FMT_IDLE,
    DBR_FMT_WALK
  } dbr_fmt_t;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] lbn_reg;
  logic [9:0] cyl_reg;
  logic [1:0] head_reg;
  logic [6:0] sector_reg;
  logic range_err_reg;
  logic [9:0] fmt_cyl_reg;
  logic [1:0] fmt_head_reg;
  logic fmt_refused_reg;
  logic [69:0] defect_reg;
  logic [6:0] tbl_idx_reg;
  logic [6:0] scan_tgt_reg;
  logic [6:0] alt_lsec_reg;
  logic [6:0] alt_cnt_reg;
  logic [14:0] tbl_mem [0:69];
  dbr_fmt_t fmt_state_reg;
  logic [6:0] fmt_i_reg;
  logic [6:0] fmt_p_reg;
  logic [6:0] fmt_k_reg;
  logic [1:0] fmt_nd_reg;
  logic [1:0] fmt_lvl_reg;
  logic [6:0] fmt_split_reg;
  logic fmt_special_reg;
  logic apb_access;
  logic apb_wr;
  logic [7:0] offs;
  logic mapped;
  logic [31:0] rd_mux;
  logic go_conv;
  logic go_fmt;
  logic go_scan;
  logic four_head;
  logic [15:0] lbn_max;
  logic div_busy;
  logic div_done;
  logic [15:0] div_quot;
  logic [15:0] div_rem;
  logic scan_busy;
  logic scan_found;
  logic [6:0] scan_phys;
  logic [6:0] scan_addr;
  logic [14:0] scan_data;
  logic [6:0] p0;
  logic [7:0] p68;
  logic [7:0] p69;
  logic [6:0] pos68;
  logic [6:0] pos69;
  logic [6:0] total_def;
  logic [6:0] primary;
  logic cur_def;
  logic [6:0] ent_lsec;
  logic [7:0] ent_flags;
  logic ent_consume;
  logic ent_secondary;
  logic [1:0] id_retry;
  logic [7:0] id_offset;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] interleave(input logic [6:0] k, input logic [6:0] split);
    interleave = k[0] ? (split + {1'b0, k[6:1]}) : {1'b0, k[6:1]};
  endfunction

  function automatic logic [7:0] disp_flag(input logic [1:0] lvl);
    disp_flag = (lvl == 2'd1) ? DBR_FLAG_DISP1 : ((lvl == 2'd2) ? DBR_FLAG_DISP2 : 8'h00);
  endfunction

  function automatic logic [6:0] popcount(input logic [69:0] v);
    logic [6:0] n;
    n = '0;
    for (int j = 0; j < 70; j++) begin
      n = n + {6'd0, v[j]};
    end
    popcount = n;
  endfunction

  // ---------------------------------------------------------------
  // apb slave, one wait state on every access
  // ---------------------------------------------------------------
  assign apb_access = psel && penable && pready;
  assign apb_wr = apb_access && pwrite && mapped;
  assign offs = paddr[7:0];
  assign mapped = (paddr[ADDR_W-1:8] == '0) && (offs[1:0] == 2'b00) && (offs <= DBR_OFS_SCAN_TGT);
  assign go_conv = apb_wr && (offs == DBR_OFS_CTRL) && pwdata[DBR_CTRL_GO_CONV];
  assign go_fmt = apb_wr && (offs == DBR_OFS_CTRL) && pwdata[DBR_CTRL_GO_FMT];
  assign go_scan = apb_wr && (offs == DBR_OFS_CTRL) && pwdata[DBR_CTRL_GO_SCAN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (offs)
      DBR_OFS_CTRL: rd_mux = {24'h000000, 4'h0, ctrl_reg[3:0]};
      DBR_OFS_LBN: rd_mux = {16'h0000, lbn_reg};
      DBR_OFS_RESULT: rd_mux = {6'd0, (ctrl_reg[DBR_CTRL_WRITE_OP] && cyl_reg == DEFECT_MAP_CYL), range_err_reg,
                                1'b0, sector_reg, 2'd0, head_reg, 2'd0, cyl_reg};
      DBR_OFS_STATUS: rd_mux = {id_offset, 8'h00, 1'b0, scan_phys, 3'd0, scan_found, fmt_refused_reg, scan_busy,
                                (fmt_state_reg == DBR_FMT_WALK), div_busy};
      DBR_OFS_FMT_TRACK: rd_mux = {18'd0, fmt_head_reg, 2'd0, fmt_cyl_reg};
      DBR_OFS_DEFECT0: rd_mux = defect_reg[31:0];
      DBR_OFS_DEFECT1: rd_mux = defect_reg[63:32];
      DBR_OFS_DEFECT2: rd_mux = {26'd0, defect_reg[69:64]};
      DBR_OFS_TBL_IDX: rd_mux = {25'd0, tbl_idx_reg};
      DBR_OFS_TBL_DATA: rd_mux = {16'h0000, tbl_mem[tbl_idx_reg][14:7], 1'b0, tbl_mem[tbl_idx_reg][6:0]};
      DBR_OFS_ALT: rd_mux = {alt_cnt_reg, DBR_SPARE_CYL[8:0], DBR_FLAG_ALTERNATE, 1'b0, alt_lsec_reg}; // [R8]
      DBR_OFS_SCAN_TGT: rd_mux = {25'd0, scan_tgt_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= DBR_CTRL_RESET;
      lbn_reg <= '0;
      fmt_cyl_reg <= '0;
      fmt_head_reg <= '0;
      defect_reg <= '0;
      tbl_idx_reg <= '0;
      scan_tgt_reg <= '0;
    end else if (apb_wr) begin
      case (offs)
        DBR_OFS_CTRL: ctrl_reg <= {28'd0, pwdata[3:0]};
        DBR_OFS_LBN: lbn_reg <= pwdata[15:0];
        DBR_OFS_FMT_TRACK: begin
          fmt_cyl_reg <= pwdata[9:0];
          fmt_head_reg <= pwdata[13:12];
        end
        DBR_OFS_DEFECT0: defect_reg[31:0] <= pwdata;
        DBR_OFS_DEFECT1: defect_reg[63:32] <= pwdata;
        DBR_OFS_DEFECT2: defect_reg[69:64] <= pwdata[5:0];
        DBR_OFS_TBL_IDX: tbl_idx_reg <= (pwdata[6:0] < DBR_SECTORS) ? pwdata[6:0] : 7'h00;
        DBR_OFS_SCAN_TGT: scan_tgt_reg <= pwdata[6:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // id field placement after failed reads
  // ---------------------------------------------------------------
  assign id_retry = ctrl_reg[DBR_CTRL_ID_RETRY_LO+1:DBR_CTRL_ID_RETRY_LO];
  assign id_offset = (id_retry == 2'd0) ? 8'h00 : ((id_retry == 2'd1) ? DBR_ID_STEP : {DBR_ID_STEP[6:0], 1'b0}); // [R9]

  // ---------------------------------------------------------------
  // block number conversion
  // ---------------------------------------------------------------
  assign four_head = ctrl_reg[DBR_CTRL_FOUR_HEAD];
  assign lbn_max = four_head ? DBR_LBN_MAX_4H : DBR_LBN_MAX_2H;

  dbr_div #(
    .W(16)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(go_conv && (lbn_reg <= lbn_max) && !div_busy), // [R11]
    .dividend(lbn_reg),
    .divisor(DBR_BLOCKS_PER_TRACK),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot),
    .rem(div_rem)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyl_reg <= '0;
      head_reg <= '0;
      sector_reg <= '0;
      range_err_reg <= 1'b0;
    end else if (go_conv && !div_busy && lbn_reg > lbn_max) begin
      range_err_reg <= 1'b1; // [R11]
    end else if (div_done) begin
      range_err_reg <= 1'b0;
      // track = cylinder * heads + head [R12] [R14]
      cyl_reg <= four_head ? div_quot[11:2] : div_quot[10:1];
      head_reg <= four_head ? div_quot[1:0] : {1'b0, div_quot[0]};
      sector_reg <= {div_rem[5:0], 1'b0}; // [R13]
    end
  end

  // ---------------------------------------------------------------
  // format planner: builds the id table of one track
  // ---------------------------------------------------------------
  assign p0 = DBR_HEAD_SKEW * {5'd0, fmt_head_reg}; // [R16]
  assign p68 = {1'b0, p0} + {1'b0, DBR_SPARE_A};
  assign p69 = {1'b0, p0} + {1'b0, DBR_SPARE_B};
  assign pos68 = (p68 >= {1'b0, DBR_SECTORS}) ? 7'(p68 - {1'b0, DBR_SECTORS}) : p68[6:0];
  assign pos69 = (p69 >= {1'b0, DBR_SECTORS}) ? 7'(p69 - {1'b0, DBR_SECTORS}) : p69[6:0];
  assign total_def = popcount(defect_reg);
  assign primary = (total_def > 7'd2) ? 7'd2 : total_def;
  assign cur_def = defect_reg[fmt_p_reg];

  always_comb begin
    ent_lsec = interleave(fmt_k_reg, fmt_split_reg); // [R15]
    ent_flags = disp_flag(fmt_lvl_reg); // [R2]
    ent_consume = 1'b1;
    ent_secondary = 1'b0;
    if (cur_def && fmt_special_reg && fmt_i_reg >= DBR_SPARE_A) begin
      ent_lsec = fmt_i_reg;
      ent_flags = DBR_FLAG_DEFECTIVE; // [R3]
      ent_consume = 1'b0;
    end else if (cur_def && fmt_nd_reg == 2'd0) begin
      ent_lsec = DBR_SPARE_A;
      ent_flags = DBR_FLAG_DEFECTIVE | DBR_FLAG_DISP1; // [R1]
      ent_consume = 1'b0;
    end else if (cur_def && fmt_nd_reg == 2'd1) begin
      ent_lsec = DBR_SPARE_B;
      ent_flags = DBR_FLAG_DEFECTIVE | DBR_FLAG_DISP2; // [R4] [R5]
      ent_consume = 1'b0;
    end else if (cur_def) begin
      // keeps its logical name, moved off track, still displaced [R6] [R7]
      ent_flags = DBR_FLAG_DEFECTIVE | DBR_FLAG_REASSIGNED | disp_flag(fmt_lvl_reg);
      ent_secondary = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_state_reg <= DBR_FMT_IDLE;
      fmt_i_reg <= '0;
      fmt_p_reg <= '0;
      fmt_k_reg <= '0;
      fmt_nd_reg <= '0;
      fmt_lvl_reg <= '0;
      fmt_split_reg <= DBR_HALF_SECTORS;
      fmt_special_reg <= 1'b0;
      fmt_refused_reg <= 1'b0;
      alt_lsec_reg <= '0;
      alt_cnt_reg <= '0;
    end else begin
      case (fmt_state_reg)
        DBR_FMT_IDLE: begin
          if (go_fmt && fmt_cyl_reg == DEFECT_MAP_CYL) begin
            fmt_refused_reg <= 1'b1; // [R10]
          end else if (go_fmt) begin
            fmt_refused_reg <= 1'b0;
            fmt_state_reg <= DBR_FMT_WALK;
            fmt_i_reg <= '0;
            fmt_p_reg <= p0;
            fmt_k_reg <= '0;
            fmt_nd_reg <= '0;
            fmt_lvl_reg <= '0;
            alt_cnt_reg <= '0;
            alt_lsec_reg <= '0;
            fmt_special_reg <= (total_def == 7'd2) && defect_reg[pos68] && defect_reg[pos69]; // [R3]
            if ((total_def == 7'd2) && defect_reg[pos68] && defect_reg[pos69]) begin
              fmt_split_reg <= DBR_HALF_SECTORS;
            end else begin
              fmt_split_reg <= DBR_HALF_SECTORS - primary; // [R2]
            end
          end
        end
        DBR_FMT_WALK: begin
          if (ent_consume) begin
            fmt_k_reg <= fmt_k_reg + 7'h01;
          end
          if (cur_def && !fmt_special_reg && fmt_nd_reg != 2'd2) begin
            fmt_nd_reg <= fmt_nd_reg + 2'd1;
            fmt_lvl_reg <= fmt_nd_reg + 2'd1;
          end
          if (ent_secondary) begin
            alt_cnt_reg <= alt_cnt_reg + 7'h01;
            if (alt_cnt_reg == 7'h00) begin
              alt_lsec_reg <= ent_lsec; // [R8]
            end
          end
          fmt_p_reg <= (fmt_p_reg == DBR_SECTORS - 7'h01) ? 7'h00 : fmt_p_reg + 7'h01;
          fmt_i_reg <= fmt_i_reg + 7'h01;
          if (fmt_i_reg == DBR_SECTORS - 7'h01) begin
            fmt_state_reg <= DBR_FMT_IDLE;
          end
        end
        default: fmt_state_reg <= DBR_FMT_IDLE;
      endcase
    end
  end

  // id table, indexed by physical position
  always_ff @(posedge pclk) begin
    if (fmt_state_reg == DBR_FMT_WALK) begin
      tbl_mem[fmt_p_reg] <= {ent_flags, ent_lsec};
    end
  end

  // ---------------------------------------------------------------
  // sector search by id match
  // ---------------------------------------------------------------
  assign scan_data = tbl_mem[scan_addr];

  dbr_scan u_scan (
    .pclk(pclk),
    .presetn(presetn),
    .start(go_scan && !scan_busy && fmt_state_reg == DBR_FMT_IDLE), // [R17]
    .target(scan_tgt_reg),
    .rd_data(scan_data),
    .rd_addr(scan_addr),
    .busy(scan_busy),
    .found(scan_found),
    .phys(scan_phys)
  );

endmodule

//--- dbr_props.sv
// apb port checker for the block remap top
`timescale 1ns/1ps
module dbr_props #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----
  // helpers
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bad_addr;
  assign bad_addr = (paddr > 12'h02c) || (paddr[1:0] != 2'h0);
  sequence seq_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence seq_answer;
    !pready ##1 pready;
  endsequence
  // ----
  // assertions
  // ----
  AST_ONE_WAIT: assert property (seq_setup |-> seq_answer)
    else $error("pready not after one wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_IN_ACCESS: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  AST_ERR_CAUSE: assert property (pready && bad_addr |-> pslverr)
    else $error("unmapped access without pslverr");
  AST_ERR_ONLY: assert property (pslverr |-> pready && !bad_addr == 1'b0)
    else $error("pslverr on mapped access");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returns data");
  AST_HOLD: assert property (pready |=> $stable(prdata))
    else $error("read data not held");
  AST_GO_ZERO: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[10:8] == 3'h0)
    else $error("start bits read back high");
  AST_RETRY: assert property (pready && !pwrite && paddr == 12'h00c |->
    prdata[31:24] inside {8'h00, 8'h40, 8'h80})
    else $error("id offset not 0, 64 or 128");
endmodule
bind dbr_top dbr_props #(.ADDR_W(ADDR_W)) dbr_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

//--- dbr_req.sv
// apb requester model that drives the remap block
`timescale 1ns/1ps
module dbr_req (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // ----
  // one transfer, held until pready seen high
  // ----
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- dbr_tb.sv
// self-checking bench for the block remap top
`timescale 1ns/1ps
module tb
  import dbr_pkg::*;
;
  localparam logic [9:0] MAP_CYL = 10'h00a;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, f;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_errors, tests_run, cyc;
  dbr_top #(.ADDR_W(12), .DEFECT_MAP_CYL(MAP_CYL)) dbr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  dbr_req dbr_req_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #50 pclk = ~pclk;
  // ----
  // shared tasks
  // ----
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    tests_run++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    dbr_req_i.xfer(1'b1, {4'h0, a}, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    dbr_req_i.xfer(1'b0, {4'h0, a}, 32'h0, q, e);
  endtask
  task automatic wait_idle(input int b);
    do begin
      rd(DBR_OFS_STATUS);
    end while (q[b] !== 1'b0);
  endtask
  function automatic logic [31:0] exp_result(input logic [15:0] lbn, input logic four);
    int t, h;
    t = lbn / 34;
    h = four ? 4 : 2;
    exp_result = ((2 * (lbn % 34)) << 16) | ((t % h) << 12) | (t / h);
  endfunction
  task automatic conv(input logic [15:0] lbn, input logic four, input logic wop);
    int t, h;
    logic [31:0] ex;
    t = lbn / 34;
    h = four ? 4 : 2;
    ex = exp_result(lbn, four);
    wr(DBR_OFS_CTRL, {30'h0, wop, four});
    wr(DBR_OFS_LBN, {16'h0, lbn});
    wr(DBR_OFS_CTRL, {23'h0, 1'b1, 6'h0, wop, four});
    wait_idle(0);
    rd(DBR_OFS_RESULT);
    if (lbn > (four ? DBR_LBN_MAX_4H : DBR_LBN_MAX_2H)) begin
      chk("range_err", {31'h0, q[24]}, 32'h1);
    end else begin
      chk("result", q & 32'h007f_33ff, ex);
      chk("write_refused", {31'h0, q[25]}, {31'h0, wop && (t / h == MAP_CYL)});
    end
  endtask
  task automatic fmt(input logic [13:0] trk, input logic [69:0] dm);
    wr(DBR_OFS_FMT_TRACK, {18'h0, trk});
    wr(DBR_OFS_DEFECT0, dm[31:0]);
    wr(DBR_OFS_DEFECT1, dm[63:32]);
    wr(DBR_OFS_DEFECT2, {26'h0, dm[69:64]});
    wr(DBR_OFS_CTRL, 32'h0000_0200);
    wait_idle(1);
  endtask
  task automatic tbl(input logic [6:0] p, input logic [15:0] ex, input logic [15:0] m);
    wr(DBR_OFS_TBL_IDX, {25'h0, p});
    rd(DBR_OFS_TBL_DATA);
    chk("tbl", {16'h0, q[15:0] & m}, {16'h0, ex});
  endtask
  // ----
  // timeout
  // ----
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 50000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(32'hf406));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    conv(16'h0000, 1'b0, 1'b0);
    conv(DBR_LBN_MAX_2H, 1'b0, 1'b0);
    conv(DBR_LBN_MAX_2H + 16'h0001, 1'b0, 1'b0);
    conv(DBR_LBN_MAX_4H, 1'b1, 1'b0);
    conv(DBR_LBN_MAX_4H + 16'h0001, 1'b1, 1'b0);
    conv(16'h02a8, 1'b0, 1'b1);
    repeat (12) begin
      f = 1'($urandom % 2);
      conv(16'($urandom % (f ? 60248 : 30124)), f, 1'b0);
    end
    $display("test conversion done");
    fmt(14'h0005, 70'h0);
    tbl(7'h00, 16'h0000, 16'hff7f);
    tbl(7'h01, 16'h0023, 16'hff7f);
    tbl(7'h45, 16'h0045, 16'hff7f);
    wr(DBR_OFS_SCAN_TGT, 32'h0000_0024);
    wr(DBR_OFS_CTRL, 32'h0000_0400);
    wait_idle(2);
    chk("scan", q & 32'h0000_7f10, 32'h0000_0310);
    fmt(14'h1005, 70'h0);
    tbl(7'h0e, 16'h0000, 16'hff7f);
    tbl(7'h00, 16'h001c, 16'hff7f);
    $display("test clean track done");
    fmt(14'h0005, 70'h4000);
    tbl(7'h0e, 16'h5044, 16'hff7f);
    tbl(7'h0d, 16'h0028, 16'hff7f);
    tbl(7'h0f, 16'h1007, 16'hff7f);
    fmt(14'h0005, 70'h1000_4000);
    tbl(7'h1c, 16'h4845, 16'hff7f);
    tbl(7'h1d, 16'h0800, 16'hff00);
    fmt(14'h0005, 70'h400_1000_4000);
    tbl(7'h2a, 16'h6800, 16'hff00);
    rd(DBR_OFS_ALT);
    chk("alt", q, 32'h03bb_8014);
    fmt(14'h0005, 70'h30_0000_0000_0000_0000);
    tbl(7'h44, 16'h4044, 16'hff7f);
    tbl(7'h45, 16'h4045, 16'hff7f);
    tbl(7'h01, 16'h0023, 16'hff7f);
    $display("test defect track done");
    for (int r = 0; r < 4; r++) begin
      wr(DBR_OFS_CTRL, 32'(r) << 2);
      rd(DBR_OFS_STATUS);
      chk("id_ofs", {24'h0, q[31:24]}, (r == 0) ? 32'h0 : ((r == 1) ? 32'h40 : 32'h80));
    end
    rd(8'h30);
    chk("slverr", {31'h0, e}, 32'h1);
    fmt({4'h0, MAP_CYL}, 70'h0);
    chk("fmt_refused", {31'h0, q[3]}, 32'h1);
    $display("test misc done");
    give_verdict();
  end
endmodule
